// File: hdl/cpa_regs.svh
// Constants for the chain position and alarm block.
// Assumes inclusion by the package, design and bench files.
`ifndef CPA_REGS_SVH
`define CPA_REGS_SVH

`define CPA_NUM_CELLS      6
`define CPA_CELLS_SIX      2'b00
`define CPA_CELLS_FIVE     2'b01
`define CPA_CELLS_FOUR     2'b10
`define CPA_CELLS_THREE    2'b11
`define CPA_POS_MIDDLE     2'b00
`define CPA_POS_BOTTOM     2'b01
`define CPA_POS_TOP        2'b10
`define CPA_POS_ALONE      2'b11

`define CPA_ADDR_STATUS    4'h0
`define CPA_ADDR_CLEAR     4'h1
`define CPA_ADDR_ENABLE    4'h2
`define CPA_ADDR_CONFIG    4'h3
`define CPA_ADDR_LIVE      4'h4
`define CPA_ADDR_CTRL      4'h5
`define CPA_ENABLE_RST     3'h0
`define CPA_CTRL_RST       1'h0

`define CPA_BIT_HIGH_VOLT  0
`define CPA_BIT_LOW_VOLT   1
`define CPA_BIT_HEAT       2
`endif

// File: hdl/cpa_pkg.sv
// Types shared by the chain position and alarm block.
// Assumes the constants header sits beside it.
`include "cpa_regs.svh"
package cpa_pkg;
    typedef enum logic [1:0] {
        CPA_MIDDLE,
        CPA_BOTTOM,
        CPA_TOP,
        CPA_ALONE
    } cpa_pos_e;
    typedef logic [2:0] cpa_alarm_t;
endpackage

// File: hdl/cpa_sync.sv
// Two flip-flop synchroniser for a vector of pin levels.
// Assumes inputs come from outside the clk domain.
`timescale 1ns/1ns
module cpa_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_next;

    always_comb begin
        meta_next = d;
        q_next    = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= meta_next;
            q        <= q_next;
        end
    end
endmodule

// File: hdl/cpa_top.sv
// Strap decode, alarm merge and chain routing for one stack monitor.
// Assumes comparator results and straps as digital pins, synchronised here.
// Notes on behaviour
// - With the polarity strap low, heat alarm when either temp input is below.
// - With the polarity strap high, heat alarm when either temp input is above.
// - Cell straps 00/01/10/11 select six/five/four/three cells, top ones unused.
// - Position straps, high first: 00 middle, 01 bottom, 10 top, 11 standalone.
// - Position straps read 0 at the high rail and 1 at the low rail.
// - A bottom part is master and takes enable and test from host levels.
// - A bottom part takes alarms from above and leaves its chain outputs idle.
// - A middle part takes alarms from above and drives enable/test upward.
// - A top part ignores chain alarm inputs and leaves enable/test idle.
// - A standalone part ignores host levels and chain inputs, chain and enable/test outputs idle.
// - Each level alarm merges this part's category with all parts above.
// - Alarm outputs are low when quiet and high when alarmed.
// - Sharing strap high keeps alarms apart; low, any alarm drives all three.
// - A bottom part passes the host enable upward on its enable output.
// - Alarm outputs follow the comparators; status bits stay set until cleared by a write.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "cpa_regs.svh"
module cpa_top #(
    parameter int NCELL = `CPA_NUM_CELLS
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [NCELL-1:0] cell_over,
    input  wire logic [NCELL-1:0] cell_under,
    input  wire logic             temp_sense_a,
    input  wire logic             temp_sense_b,
    input  wire logic             temp_above_a,
    input  wire logic             temp_above_b,
    input  wire logic             thermistor_polarity_strap,
    input  wire logic             cell_count_strap_a,
    input  wire logic             cell_count_strap_b,
    input  wire logic             chain_high_flag,
    input  wire logic             chain_low_flag,
    input  wire logic             alarm_sharing_strap,
    input  wire logic             enable_chain_in,
    input  wire logic             selfcheck_in,
    input  wire logic             chain_in_high_volt,
    input  wire logic             chain_in_low_volt,
    input  wire logic             chain_in_heat,
    input  wire logic [3:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    output logic                  irq,
    output logic                  enable_chain_out,
    output logic                  selfcheck_out,
    output logic                  chain_out_high_volt,
    output logic                  chain_out_low_volt,
    output logic                  chain_out_heat,
    output logic                  level_alarm_high_volt,
    output logic                  level_alarm_low_volt,
    output logic                  level_alarm_heat,
    output cpa_pkg::cpa_pos_e     chain_pos
);
    import cpa_pkg::*;

    localparam int NIN = 2 * NCELL + 15;

    // Every pin level passes two flops first
    logic [NIN-1:0] pin_raw;
    logic [NIN-1:0] pin_s;
    assign pin_raw = {cell_over, cell_under, temp_sense_a, temp_sense_b,
                      temp_above_a, temp_above_b, thermistor_polarity_strap,
                      cell_count_strap_a, cell_count_strap_b, chain_high_flag,
                      chain_low_flag, alarm_sharing_strap, enable_chain_in,
                      selfcheck_in, chain_in_high_volt, chain_in_low_volt,
                      chain_in_heat};

    cpa_sync #(.W(NIN)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   (pin_raw),
        .q   (pin_s)
    );

    logic [NCELL-1:0] s_over;
    logic [NCELL-1:0] s_under;
    logic s_below_a, s_below_b, s_above_a, s_above_b, s_pol;
    logic s_cnt_a, s_cnt_b, s_hi_flag, s_lo_flag, s_share;
    logic s_en, s_test, s_in_hv, s_in_lv, s_in_heat;
    assign {s_over, s_under, s_below_a, s_below_b, s_above_a, s_above_b,
            s_pol, s_cnt_a, s_cnt_b, s_hi_flag, s_lo_flag, s_share,
            s_en, s_test, s_in_hv, s_in_lv, s_in_heat} = pin_s;

    // Combinational decode
    cpa_pos_e         pos_c;
    logic [NCELL-1:0] cell_mask;
    logic             own_hv;
    logic             own_lv;
    logic             own_heat;
    logic             take_chain;
    logic             drive_up;
    cpa_alarm_t       merged;
    cpa_alarm_t       shown;

    always_comb begin
        // Straps read inverted: 0 at high rail means logic 0 here
        case ({s_hi_flag, s_lo_flag})
            `CPA_POS_MIDDLE: pos_c = CPA_MIDDLE;
            `CPA_POS_BOTTOM: pos_c = CPA_BOTTOM;
            `CPA_POS_TOP:    pos_c = CPA_TOP;
            `CPA_POS_ALONE:  pos_c = CPA_ALONE;
            default:         pos_c = CPA_ALONE;
        endcase
        cell_mask = '1;
        case ({s_cnt_a, s_cnt_b})
            `CPA_CELLS_SIX:   cell_mask = '1;
            `CPA_CELLS_FIVE:  cell_mask[5] = 1'b0;
            `CPA_CELLS_FOUR:  cell_mask[5:4] = 2'b00;
            `CPA_CELLS_THREE: cell_mask[5:3] = 3'b000;
            default:          cell_mask = '1;
        endcase
        own_hv = |(s_over & cell_mask);
        own_lv = |(s_under & cell_mask);
        if (s_pol) begin
            own_heat = s_above_a | s_above_b;
        end else begin
            own_heat = s_below_a | s_below_b;
        end
        take_chain = (pos_c == CPA_BOTTOM) || (pos_c == CPA_MIDDLE);
        drive_up   = take_chain;
        merged[`CPA_BIT_HIGH_VOLT] = own_hv | (take_chain & s_in_hv);
        merged[`CPA_BIT_LOW_VOLT]  = own_lv | (take_chain & s_in_lv);
        merged[`CPA_BIT_HEAT]      = own_heat | (take_chain & s_in_heat);
        if (s_share) begin
            shown = merged;
        end else begin
            shown = {3{|merged}};
        end
    end

    // Output and register state
    logic [2:0] status_reg, status_next;
    logic [2:0] enable_reg, enable_next;
    logic       ctrl_reg, ctrl_next;
    logic [7:0] rdata_next;
    logic       irq_next;
    logic [2:0] level_next;
    logic [2:0] chain_next;
    logic       en_out_next, test_out_next;
    logic [2:0] clear_c;

    always_comb begin
        clear_c = (reg_wr && reg_addr == `CPA_ADDR_CLEAR) ? reg_wdata[2:0]
                                                          : 3'h0;
        // Set wins over clear
        status_next = (status_reg & ~clear_c) | shown;
        enable_next = enable_reg;
        ctrl_next   = ctrl_reg;
        if (reg_wr && reg_addr == `CPA_ADDR_ENABLE) begin
            enable_next = reg_wdata[2:0];
        end
        if (reg_wr && reg_addr == `CPA_ADDR_CTRL) begin
            ctrl_next = reg_wdata[0];
        end
        rdata_next = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `CPA_ADDR_STATUS: rdata_next = {5'h00, status_reg};
                `CPA_ADDR_ENABLE: rdata_next = {5'h00, enable_reg};
                `CPA_ADDR_CONFIG: rdata_next = {1'b0, s_share, s_pol,
                                                s_cnt_a, s_cnt_b,
                                                s_hi_flag, s_lo_flag, 1'b0};
                `CPA_ADDR_LIVE:   rdata_next = {3'h0, pos_c, shown};
                `CPA_ADDR_CTRL:   rdata_next = {7'h00, ctrl_reg};
                default:          rdata_next = 8'h00;
            endcase
        end
        irq_next      = |(status_next & enable_next);
        // Forced-alarm bit lets software exercise the outputs
        level_next    = shown | {3{ctrl_reg}};
        // Bottom and standalone chain outputs unused, held low
        chain_next    = (pos_c == CPA_MIDDLE || pos_c == CPA_TOP) ? level_next
                                                                  : 3'h0;
        en_out_next   = drive_up & s_en;
        test_out_next = drive_up & s_test;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_reg            <= 3'h0;
            enable_reg            <= `CPA_ENABLE_RST;
            ctrl_reg              <= `CPA_CTRL_RST;
            reg_rdata             <= 8'h00;
            irq                   <= 1'b0;
            enable_chain_out      <= 1'b0;
            selfcheck_out         <= 1'b0;
            chain_out_high_volt   <= 1'b0;
            chain_out_low_volt    <= 1'b0;
            chain_out_heat        <= 1'b0;
            level_alarm_high_volt <= 1'b0;
            level_alarm_low_volt  <= 1'b0;
            level_alarm_heat      <= 1'b0;
            chain_pos             <= CPA_ALONE;
        end else begin
            status_reg            <= status_next;
            enable_reg            <= enable_next;
            ctrl_reg              <= ctrl_next;
            reg_rdata             <= rdata_next;
            irq                   <= irq_next;
            enable_chain_out      <= en_out_next;
            selfcheck_out         <= test_out_next;
            chain_out_high_volt   <= chain_next[0];
            chain_out_low_volt    <= chain_next[1];
            chain_out_heat        <= chain_next[2];
            level_alarm_high_volt <= level_next[0];
            level_alarm_low_volt  <= level_next[1];
            level_alarm_heat      <= level_next[2];
            chain_pos             <= pos_c;
        end
    end

    // Checks
    sequence heat_cold_s;
        !s_pol && (s_below_a || s_below_b);
    endsequence
    sequence heat_hot_s;
        s_pol && (s_above_a || s_above_b);
    endsequence

    heat_ntc_a: assert property (@(posedge clk) disable iff (rst)
        heat_cold_s |=> level_alarm_heat)
        else $error("cold thermistor did not raise heat alarm");
    heat_ptc_a: assert property (@(posedge clk) disable iff (rst)
        heat_hot_s |=> level_alarm_heat)
        else $error("hot thermistor did not raise heat alarm");
    cell_mask_a: assert property (@(posedge clk) disable iff (rst)
        ({s_cnt_a, s_cnt_b} == `CPA_CELLS_THREE && s_share && !ctrl_reg
         && s_over[5:3] != 3'h0 && s_over[2:0] == 3'h0
         && !(take_chain && s_in_hv)) |=> !level_alarm_high_volt)
        else $error("shorted cell raised overvoltage");
    pos_decode_a: assert property (@(posedge clk) disable iff (rst)
        ({s_hi_flag, s_lo_flag} == `CPA_POS_BOTTOM) |=> chain_pos == CPA_BOTTOM)
        else $error("bottom position not decoded");
    top_ignore_a: assert property (@(posedge clk) disable iff (rst)
        (pos_c == CPA_TOP) |=> !enable_chain_out && !selfcheck_out)
        else $error("top part drove enable or test");
    bottom_idle_a: assert property (@(posedge clk) disable iff (rst)
        (pos_c == CPA_BOTTOM) |=> !chain_out_heat && !chain_out_high_volt)
        else $error("bottom part drove chain alarm outputs");
    enable_pass_a: assert property (@(posedge clk) disable iff (rst)
        (pos_c == CPA_BOTTOM) |=> enable_chain_out == $past(s_en))
        else $error("bottom part did not pass enable upward");
    chain_merge_a: assert property (@(posedge clk) disable iff (rst)
        (pos_c == CPA_MIDDLE && s_in_lv) |=> level_alarm_low_volt)
        else $error("chain alarm from above not merged");
    share_all_a: assert property (@(posedge clk) disable iff (rst)
        (!s_share && |merged) |=>
            level_alarm_high_volt && level_alarm_low_volt && level_alarm_heat)
        else $error("shared mode did not raise all alarms");
    alarm_quiet_a: assert property (@(posedge clk) disable iff (rst)
        (merged == 3'h0 && !ctrl_reg) |=> !level_alarm_heat)
        else $error("alarm high while quiet");
endmodule

// File: sim/cpa_upper_model.sv
// Behavioural model of the neighbouring monitor above this part.
// Assumes the bench commands its alarms; fed by this part's test output.
`timescale 1ns/1ns
module cpa_upper_model (
    input  wire logic       selfcheck_in,
    input  wire logic [2:0] alarm_cmd,
    output logic            chain_out_high_volt,
    output logic            chain_out_low_volt,
    output logic            chain_out_heat
);
    // Self-test holds every alarm high while requested
    always_comb begin
        {chain_out_heat, chain_out_low_volt, chain_out_high_volt} =
            selfcheck_in ? 3'h7 : alarm_cmd;
    end
endmodule

// File: sim/chain_position_alarm_config_tb.sv
// Self-checking bench for strap decode, alarm merge and chain routing.
// Assumes the upper neighbour model and the register port of the block.
`timescale 1ns/1ns
`include "cpa_regs.svh"
module chain_position_alarm_config_tb;
    import cpa_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [5:0] cov = '0;
    logic [5:0] cun = '0;
    logic       ta = 0, tb = 0, aa = 0, ab = 0, pol = 0, ca = 0, cb = 0;
    logic       hi = 0, lo = 0, share = 0, en_in = 0, tst_in = 0;
    logic [2:0] cmd = '0;
    logic [3:0] addr = '0;
    logic [7:0] wdata = '0;
    logic       wr = 0, rd = 0, snap = 0, rd_d = 0;
    wire        up_hv, up_lv, up_ht, en_out, tst_out, irq;
    wire  [2:0] co, lvl;
    wire  [7:0] rdata;
    cpa_pos_e   pos;
    logic [10:0] exp_q[$];
    logic [7:0]  rd_q[$];
    int         errors = 0, checks_done = 0, cycles = 0;

    always #2 clk = ~clk;

    cpa_top DUT (.clk(clk), .rst(rst), .cell_over(cov), .cell_under(cun),
        .temp_sense_a(ta), .temp_sense_b(tb), .temp_above_a(aa),
        .temp_above_b(ab), .thermistor_polarity_strap(pol),
        .cell_count_strap_a(ca), .cell_count_strap_b(cb),
        .chain_high_flag(hi), .chain_low_flag(lo),
        .alarm_sharing_strap(share), .enable_chain_in(en_in),
        .selfcheck_in(tst_in), .chain_in_high_volt(up_hv),
        .chain_in_low_volt(up_lv), .chain_in_heat(up_ht),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .irq(irq), .enable_chain_out(en_out),
        .selfcheck_out(tst_out), .chain_out_high_volt(co[0]),
        .chain_out_low_volt(co[1]), .chain_out_heat(co[2]),
        .level_alarm_high_volt(lvl[0]), .level_alarm_low_volt(lvl[1]),
        .level_alarm_heat(lvl[2]), .chain_pos(pos));

    cpa_upper_model upper (.selfcheck_in(tst_out), .alarm_cmd(cmd),
        .chain_out_high_volt(up_hv), .chain_out_low_volt(up_lv),
        .chain_out_heat(up_ht));

    // Expected pin picture from the present straps and inputs
    function automatic logic [10:0] model(input logic irq_e,
                                          input logic frc = 1'b0);
        logic [1:0] p;
        logic [2:0] up, loc, comb, shown, lvl_e;
        logic [5:0] m;
        p = {hi, lo};
        m = 6'h3f >> {ca, cb};
        loc[0] = |(cov & m);
        loc[1] = |(cun & m);
        loc[2] = pol ? (aa | ab) : (ta | tb);
        up = (p <= 2'd1) ? (tst_in ? 3'h7 : cmd) : 3'h0;
        comb = loc | up;
        shown = share ? comb : {3{|comb}};
        // Force bit drives every level alarm and the chain copy
        lvl_e = shown | {3{frc}};
        return {p, (p <= 2'd1) ? {en_in, tst_in} : 2'b00,
                (p == 2'd0 || p == 2'd2) ? lvl_e : 3'h0, lvl_e, irq_e};
    endfunction

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic compare_pins(input logic [10:0] e);
        logic [10:0] act;
        act = {pos, en_out, tst_out, co, lvl, irq};
        checks_done++;
        if (act !== e) begin
            errors++;
            $display("CHECK FAILED at %0t: pins %h expected %h",
                     $time, act, e);
        end
    endtask

    task automatic compare_read(input logic [7:0] act, input logic [7:0] e);
        checks_done++;
        if (act !== e) begin
            errors++;
            $display("CHECK FAILED at %0t: read %h expected %h",
                     $time, act, e);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic read_expect(input logic [3:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask

    task automatic expect_pins(input logic [10:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        snap <= 1'b1;
        @(posedge clk);
        snap <= 1'b0;
    endtask

    // Watcher: compares results as they appear
    always @(posedge clk) begin
        rd_d <= rd;
        if (snap) compare_pins(exp_q.pop_front());
        if (rd_d) compare_read(rdata, rd_q.pop_front());
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors++;
            $display("CHECK FAILED at %0t: run too long", $time);
            print_verdict;
        end
    end

    initial begin
        void'($urandom(32'h20c2));
        tick(3);
        exp_q.push_back(11'h600);
        rst <= 1'b0;
        snap <= 1'b1;
        tick(1);
        snap <= 1'b0;
        $display("Test reset done");
        for (int i = 0; i < 48; i++) begin
            {hi, lo, ca, cb, pol, share, en_in, tst_in} <= 8'($urandom);
            {ta, tb, aa, ab} <= 4'($urandom) & 4'($urandom);
            cmd <= 3'($urandom);
            cov <= 6'h1 << ($urandom % 8);
            cun <= 6'h1 << ($urandom % 8);
            tick(9);
            expect_pins(model(1'b0));
        end
        $display("Test strap and chain decode done");
        {cov, cun, ta, tb, aa, ab, cmd} <= '0;
        {hi, lo, ca, cb, pol, tst_in} <= '0;
        share <= 1'b1;
        tick(9);
        bus(1'b1, `CPA_ADDR_CLEAR, 8'h07);
        bus(1'b1, `CPA_ADDR_STATUS, 8'hff);
        read_expect(`CPA_ADDR_STATUS, 8'h00);
        read_expect(4'hf, 8'h00);
        bus(1'b1, `CPA_ADDR_ENABLE, 8'h04);
        read_expect(`CPA_ADDR_ENABLE, 8'h04);
        read_expect(`CPA_ADDR_CONFIG, 8'h40);
        cmd <= 3'h4;
        tick(9);
        expect_pins(model(1'b1));
        read_expect(`CPA_ADDR_LIVE, 8'h04);
        read_expect(`CPA_ADDR_STATUS, 8'h04);
        bus(1'b1, `CPA_ADDR_ENABLE, 8'h00);
        tick(2);
        expect_pins(model(1'b0));
        cmd <= 3'h0;
        tick(9);
        bus(1'b1, `CPA_ADDR_CLEAR, 8'h04);
        read_expect(`CPA_ADDR_STATUS, 8'h00);
        bus(1'b1, `CPA_ADDR_ENABLE, 8'h04);
        tick(2);
        expect_pins(model(1'b0));
        bus(1'b1, `CPA_ADDR_CTRL, 8'h01);
        read_expect(`CPA_ADDR_CTRL, 8'h01);
        tick(2);
        expect_pins(model(1'b0, 1'b1));
        read_expect(`CPA_ADDR_STATUS, 8'h00);
        bus(1'b1, `CPA_ADDR_CTRL, 8'h00);
        tick(3);
        $display("Test registers and interrupt done");
        print_verdict;
    end
endmodule
